//--- design/exc_seq_pkg.sv
/*
  constants shared by the exception sequencer and its reset pulse generator.
  assumes one 20 MHz core bus clock and an 8-bit data, 16-bit address bus.
*/
package exc_seq_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_DRIVE_CYCLES = 16; // pin held low, bus clock cycles
  localparam int RST_HOLD_CYCLES = 16; // further internal reset, pin released
  localparam logic [5:0] RST_CNT_W_MAX = 6'(RST_DRIVE_CYCLES + RST_HOLD_CYCLES - 1);
  localparam logic [5:0] RST_CNT_DRIVE_END = 6'(RST_DRIVE_CYCLES - 1);

  // vectors and reset values
  localparam logic [15:0] VEC_USER_HI = 16'hFFFE;
  localparam int VEC_MONITOR_BIT = 8; // address bit forced low in monitor mode
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] H_RESET = 8'h00;
  localparam logic [6:0] VEC_CODE_RESET = 7'h00;
  localparam logic [6:0] VEC_CODE_TRAP = 7'h01;
  localparam int CCR_MASK_BIT = 3;

  // opcodes decoded by the sequencer (plain defaults)
  localparam logic [7:0] software_trap_opcode = 8'h83;
  localparam logic [7:0] return_from_exception_op = 8'h80;
  localparam logic [7:0] set_mask_op = 8'h9B;
  localparam logic [7:0] clear_mask_op = 8'h9A;
  localparam logic [7:0] acc_to_ccr_op = 8'h84;

  // sequencer states, gray coded along entry, vector and return paths, except the ST_RUN to ST_R_SP and ST_V_CAP to ST_RUN steps
  typedef enum logic [4:0] {
    ST_RUN = 5'h00,
    ST_E_ADJ = 5'h01,
    ST_E_PCL = 5'h03,
    ST_E_PCH = 5'h02,
    ST_E_X = 5'h06,
    ST_E_A = 5'h07,
    ST_E_CCR = 5'h05,
    ST_V_H = 5'h04,
    ST_V_L = 5'h0C,
    ST_V_CAP = 5'h0D,
    ST_R_SP = 5'h0F,
    ST_R_CCR = 5'h0E,
    ST_R_A = 5'h0A,
    ST_R_X = 5'h0B,
    ST_R_PCH = 5'h09,
    ST_R_PCL = 5'h08
  } seq_state_t;
endpackage : exc_seq_pkg

//--- design/reset_pulse_gen.sv
/*
  active reset pulse generator: drives the reset pin low, then holds internal
  reset with the pin released, then samples the pin to name the source.
  assumes the pin level arrives synchronous to mclk.
*/
`timescale 1ns/1ps
module reset_pulse_gen
  import exc_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic internal_src,
  input wire logic reset_pin_in,
  output logic reset_pin_oe,
  output logic int_reset_reg,
  output logic internal_flag_reg
);
  logic [5:0] cnt_reg;
  logic busy_reg;

  //////////////////////////////////////////////////////////////////////////
  // pulse sequence: drive phase, hold phase, then sample the pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      reset_pin_oe <= 1'b0;
      int_reset_reg <= 1'b1;
      internal_flag_reg <= 1'b0;
    end else if (!busy_reg && internal_src) begin
      busy_reg <= 1'b1;
      cnt_reg <= 6'h00;
      reset_pin_oe <= 1'b1;
      int_reset_reg <= 1'b1;
      internal_flag_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 6'h01;
      if (cnt_reg == RST_CNT_DRIVE_END) begin
        reset_pin_oe <= 1'b0;
      end
      if (cnt_reg == RST_CNT_W_MAX) begin
        busy_reg <= 1'b0;
        int_reset_reg <= !reset_pin_in;
        internal_flag_reg <= reset_pin_in;
      end
    end else begin
      int_reset_reg <= !reset_pin_in; // external pin reset
    end
  end
endmodule : reset_pulse_gen

//--- design/cpu_reset_interrupt_sequencer.sv
/*
  exception sequencer of an 8-bit core: interrupt recognition at instruction
  boundaries, forced trap opcode, stacking and unstacking, mask timing,
  reset vector fetch and reset pin pulse.
  assumes memory answers a read in the same cycle its strobe is high, and
  that the core stalls while seq_busy is high.
*/
`timescale 1ns/1ps
module cpu_reset_interrupt_sequencer
  import exc_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic last_cycle,
  input wire logic op_first,
  input wire logic [7:0] next_opcode,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] x_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] ccr_in,
  input wire logic h_load,
  input wire logic [7:0] h_in,
  input wire logic irq_pending,
  input wire logic irq_local_en,
  input wire logic [6:0] vec_code,
  input wire logic internal_reset_src,
  input wire logic reset_pin_in,
  input wire logic monitor_strap,
  input wire logic stop_enter,
  input wire logic wait_enter,
  input wire logic [7:0] bus_rdata,
  output logic [15:0] bus_addr_reg,
  output logic [7:0] bus_wdata_reg,
  output logic bus_rd_reg,
  output logic bus_wr_reg,
  output logic [7:0] opcode_holding_register,
  output logic [15:0] pc_reg,
  output logic pc_load_reg,
  output logic [15:0] sp_reg,
  output logic [7:0] h_reg,
  output logic ccr_mask_reg,
  output logic [7:0] a_restore_reg,
  output logic [7:0] x_restore_reg,
  output logic [7:0] ccr_restore_reg,
  output logic restore_valid_reg,
  output logic seq_busy_reg,
  output logic irq_ack_reg,
  output logic monitor_mode_reg,
  output logic stop_latch_reg,
  output logic wait_latch_reg,
  output logic reset_pin_oe,
  output logic internal_reset_flag
);
  seq_state_t state_reg, state_next;
  logic core_rst;
  logic int_reset;
  logic irq_seen_reg;
  logic pin_prev_reg;
  logic hw_entry_reg;
  logic [15:0] ret_pc_reg;
  logic [6:0] code_reg;
  logic take_hw;
  logic take_trap;
  logic take_ret;
  logic [15:0] addr_c;
  logic [7:0] wdata_c;
  logic rd_c;
  logic wr_c;
  logic [15:0] vec_addr;

  // vector address of a priority code, A8 cleared in monitor mode
  function automatic logic [15:0] vector_of(input logic [6:0] code, input logic mon);
    logic [15:0] v;
    v = VEC_USER_HI - {8'h00, code, 1'b0};
    if (mon) begin
      v[VEC_MONITOR_BIT] = 1'b0;
    end
    return v;
  endfunction : vector_of

  // opcodes that rewrite the mask in their first cycle
  function automatic logic is_mask_op(input logic [7:0] op);
    return (op == set_mask_op) || (op == clear_mask_op) || (op == acc_to_ccr_op);
  endfunction : is_mask_op

  //////////////////////////////////////////////////////////////////////////
  // reset pin pulse and source sampling
  reset_pulse_gen u_rst_pulse (
    .mclk(mclk),
    .rst(rst),
    .internal_src(internal_reset_src),
    .reset_pin_in(reset_pin_in),
    .reset_pin_oe(reset_pin_oe),
    .int_reset_reg(int_reset),
    .internal_flag_reg(internal_reset_flag)
  );

  // every reset source shares one path, ahead of all requests
  assign core_rst = rst || int_reset;

  //////////////////////////////////////////////////////////////////////////
  // boundary decisions, only in the final cycle of an instruction
  assign take_hw = (state_reg == ST_RUN) && last_cycle && irq_seen_reg && !ccr_mask_reg;
  assign take_trap = (state_reg == ST_RUN) && last_cycle && !take_hw
    && (next_opcode == software_trap_opcode);
  assign take_ret = (state_reg == ST_RUN) && last_cycle && !take_hw
    && (next_opcode == return_from_exception_op);
  assign vec_addr = vector_of(code_reg, monitor_mode_reg);

  // request seen a cycle late, so a last-cycle arrival waits a boundary
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      irq_seen_reg <= 1'b0;
    end else begin
      irq_seen_reg <= irq_pending && irq_local_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state and bus access of the current state
  always_comb begin
    state_next = state_reg;
    addr_c = sp_reg;
    wdata_c = 8'h00;
    rd_c = 1'b0;
    wr_c = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (take_hw || take_trap) begin
          state_next = ST_E_ADJ;
        end else if (take_ret) begin
          state_next = ST_R_SP;
        end
      end
      ST_E_ADJ: state_next = ST_E_PCL;
      ST_E_PCL: begin
        wr_c = 1'b1;
        wdata_c = ret_pc_reg[7:0];
        state_next = ST_E_PCH;
      end
      ST_E_PCH: begin
        wr_c = 1'b1;
        wdata_c = ret_pc_reg[15:8];
        state_next = ST_E_X;
      end
      ST_E_X: begin
        wr_c = 1'b1;
        wdata_c = x_in;
        state_next = ST_E_A;
      end
      ST_E_A: begin
        wr_c = 1'b1;
        wdata_c = a_in;
        state_next = ST_E_CCR;
      end
      ST_E_CCR: begin
        wr_c = 1'b1;
        wdata_c = ccr_in;
        wdata_c[CCR_MASK_BIT] = ccr_mask_reg;
        state_next = ST_V_H;
      end
      ST_V_H: begin
        rd_c = 1'b1;
        addr_c = vec_addr;
        state_next = ST_V_L;
      end
      ST_V_L: begin
        rd_c = 1'b1;
        addr_c = vec_addr + 16'h0001;
        state_next = ST_V_CAP;
      end
      ST_V_CAP: state_next = ST_RUN;
      ST_R_SP, ST_R_CCR, ST_R_A, ST_R_X, ST_R_PCH: begin
        rd_c = 1'b1;
        addr_c = sp_reg + 16'h0001;
        case (state_reg)
          ST_R_SP: state_next = ST_R_CCR;
          ST_R_CCR: state_next = ST_R_A;
          ST_R_A: state_next = ST_R_X;
          ST_R_X: state_next = ST_R_PCH;
          default: state_next = ST_R_PCL;
        endcase
      end
      ST_R_PCL: state_next = ST_RUN;
      default: state_next = ST_V_H;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; reset starts the vector fetch
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      state_reg <= ST_V_H;
      seq_busy_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      seq_busy_reg <= (state_next != ST_RUN);
    end
  end

  // registered bus strobes, one cycle after the issuing state
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      bus_addr_reg <= 16'h0000;
      bus_wdata_reg <= 8'h00;
      bus_rd_reg <= 1'b0;
      bus_wr_reg <= 1'b0;
    end else begin
      bus_addr_reg <= addr_c;
      bus_wdata_reg <= wdata_c;
      bus_rd_reg <= rd_c;
      bus_wr_reg <= wr_c;
    end
  end

  // stack pointer: decrement after push, increment before pull
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      sp_reg <= SP_RESET;
    end else if (wr_c) begin
      sp_reg <= sp_reg - 16'h0001;
    end else if (rd_c && (state_reg != ST_V_H) && (state_reg != ST_V_L)) begin
      sp_reg <= sp_reg + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // opcode holding register and entry capture
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      opcode_holding_register <= 8'h00;
      hw_entry_reg <= 1'b0;
      ret_pc_reg <= 16'h0000;
      code_reg <= VEC_CODE_RESET;
    end else if (state_reg == ST_RUN && last_cycle) begin
      if (take_hw) begin
        opcode_holding_register <= software_trap_opcode;
        hw_entry_reg <= 1'b1;
        ret_pc_reg <= pc_in - 16'h0001;
        code_reg <= vec_code;
      end else begin
        opcode_holding_register <= next_opcode;
        hw_entry_reg <= 1'b0;
        ret_pc_reg <= pc_in;
        code_reg <= VEC_CODE_TRAP;
      end
    end else if (state_reg == ST_R_PCH) begin
      ret_pc_reg[15:8] <= bus_rdata;
    end else if (state_reg == ST_V_L) begin
      ret_pc_reg[15:8] <= bus_rdata;
    end
  end

  // program counter load at end of vector fetch or return
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      pc_reg <= 16'h0000;
      pc_load_reg <= 1'b0;
      irq_ack_reg <= 1'b0;
    end else begin
      pc_load_reg <= 1'b0;
      irq_ack_reg <= 1'b0;
      if (state_reg == ST_V_CAP || state_reg == ST_R_PCL) begin
        pc_reg <= {ret_pc_reg[15:8], bus_rdata};
        pc_load_reg <= 1'b1;
        irq_ack_reg <= (state_reg == ST_V_CAP) && hw_entry_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // global mask: reset, entry cycle six, mask opcodes, return cycle two
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      ccr_mask_reg <= 1'b1;
    end else if (state_reg == ST_E_CCR) begin
      ccr_mask_reg <= 1'b1;
    end else if (state_reg == ST_R_CCR) begin
      ccr_mask_reg <= bus_rdata[CCR_MASK_BIT];
    end else if (state_reg == ST_RUN && op_first && is_mask_op(opcode_holding_register)) begin
      case (opcode_holding_register)
        set_mask_op: ccr_mask_reg <= 1'b1;
        clear_mask_op: ccr_mask_reg <= 1'b0;
        default: ccr_mask_reg <= a_in[CCR_MASK_BIT];
      endcase
    end
  end

  // restored register values handed back to the core
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      a_restore_reg <= 8'h00;
      x_restore_reg <= 8'h00;
      ccr_restore_reg <= 8'h00;
      restore_valid_reg <= 1'b0;
    end else begin
      restore_valid_reg <= (state_reg == ST_R_PCL);
      case (state_reg)
        ST_R_CCR: ccr_restore_reg <= bus_rdata;
        ST_R_A: a_restore_reg <= bus_rdata;
        ST_R_X: x_restore_reg <= bus_rdata;
        default: ccr_restore_reg <= ccr_restore_reg;
      endcase
    end
  end

  // index high byte: reset clears it, exception flows never touch it
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      h_reg <= H_RESET;
    end else if (h_load && state_reg == ST_RUN) begin
      h_reg <= h_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode caught on the rising edge of the reset pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
      monitor_mode_reg <= 1'b0;
    end else begin
      pin_prev_reg <= reset_pin_in;
      if (reset_pin_in && !pin_prev_reg) begin
        monitor_mode_reg <= monitor_strap;
      end
    end
  end

  // low power latches, cleared by reset and by exception entry
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      stop_latch_reg <= 1'b0;
      wait_latch_reg <= 1'b0;
    end else if (state_reg == ST_E_ADJ) begin
      stop_latch_reg <= stop_enter; // a new entry request wins over the clear
      wait_latch_reg <= wait_enter;
    end else begin
      stop_latch_reg <= stop_latch_reg || stop_enter;
      wait_latch_reg <= wait_latch_reg || wait_enter;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (core_rst);

  AST_BOUNDARY_ONLY: assert property (
    (state_reg == ST_E_ADJ) |-> $past(last_cycle) && $past(state_reg == ST_RUN))
    else $error("entry started outside an instruction boundary");
  AST_FORCED_TRAP: assert property (
    take_hw |=> opcode_holding_register == software_trap_opcode ##1 bus_wr_reg == 1'b0)
    else $error("trap opcode not forced on recognition");
  AST_HW_PC_DEC: assert property (
    take_hw |-> ##3 (bus_wr_reg && bus_wdata_reg == $past(pc_in[7:0], 3) - 8'h01))
    else $error("hardware entry stacked wrong return low byte");
  AST_TRAP_PC: assert property (
    take_trap |=> ret_pc_reg == $past(pc_in))
    else $error("executed trap did not keep the program counter");
  AST_PUSH_SP: assert property (
    (state_reg == ST_E_X) |=> bus_wr_reg && bus_wdata_reg == $past(x_in) && bus_addr_reg == sp_reg + 16'h0001)
    else $error("index low byte push misplaced");
  AST_MASK_CYCLE6: assert property (
    (state_reg == ST_E_A && !ccr_mask_reg) |=> !ccr_mask_reg ##1 ccr_mask_reg)
    else $error("mask not set in cycle six of entry");
  AST_H_STABLE: assert property (
    (state_reg != ST_RUN) |=> $stable(h_reg))
    else $error("index high byte changed during exception flow");
  AST_MASK_OP: assert property (
    (state_reg == ST_RUN && op_first && opcode_holding_register == clear_mask_op) |=> !ccr_mask_reg)
    else $error("clear mask did not act in first cycle");
  AST_RET_MASK: assert property (
    (state_reg == ST_R_CCR) |=> ccr_mask_reg == $past(bus_rdata[CCR_MASK_BIT]))
    else $error("return did not restore mask from stacked byte");
  AST_RET_PC_LAST: assert property (
    (state_reg == ST_R_PCL) |=> pc_load_reg && restore_valid_reg && state_reg == ST_RUN)
    else $error("return did not finish with program counter load");
  AST_MONITOR_VEC: assert property (
    (state_reg == ST_V_L && monitor_mode_reg) |-> bus_rd_reg && !bus_addr_reg[VEC_MONITOR_BIT])
    else $error("monitor vector kept address bit 8 high");
endmodule : cpu_reset_interrupt_sequencer

//--- tb/sim_unit_model.sv
/*
  behavioural system integration unit: latches one request with its code.
  assumes the bench drives req_in and code_in on mclk.
*/
`timescale 1ns/1ps
module sim_unit_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_in,
  input wire logic [6:0] code_in,
  input wire logic irq_ack,
  output logic irq_pending,
  output logic [6:0] vec_code
);
  // hold the first selection until serviced, later requests ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_pending <= 1'b0;
      vec_code <= 7'h00;
    end else if (irq_ack) begin
      irq_pending <= 1'b0;
    end else if (req_in && !irq_pending) begin
      irq_pending <= 1'b1;
      vec_code <= code_in;
    end
  end
endmodule : sim_unit_model

//--- tb/tb_cpu_reset_interrupt_sequencer.sv
/*
  testbench of the exception sequencer: trap, hardware entry, return,
  mask ops and internal reset pulse, against a flat memory model.
  assumes the design answers per the hand-over timing.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_cpu_reset_interrupt_sequencer;
  import exc_seq_pkg::*;
  logic mclk, rst, last_cycle, op_first, h_load, irq_pending, irq_local_en, req;
  logic internal_reset_src, ext_rst_n, monitor_strap, stop_enter, wait_enter;
  logic [7:0] next_opcode, x_in, a_in, ccr_in, h_in, bus_rdata, bus_wdata_reg, opcode_holding_register;
  logic [15:0] pc_in, bus_addr_reg, pc_reg, sp_reg;
  logic [6:0] vec_code, req_code;
  logic bus_rd_reg, bus_wr_reg, pc_load_reg, ccr_mask_reg, restore_valid_reg, seq_busy_reg, irq_ack_reg;
  logic monitor_mode_reg, stop_latch_reg, wait_latch_reg, reset_pin_oe, internal_reset_flag;
  logic [7:0] h_reg, a_restore_reg, x_restore_reg, ccr_restore_reg;
  logic [7:0] mem [0:65535];
  int bad_count, total_checks, n;
  logic [7:0] mops [3];
  logic mexp [3];

  ////////////////////////////////////////////////////////////////////////
  // clock, pin with pull-up, memory answering in the strobe cycle
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  wire reset_pin_in = ext_rst_n & ~reset_pin_oe;
  assign bus_rdata = (bus_rd_reg === 1'b1) ? mem[bus_addr_reg] : ~bus_addr_reg[7:0];
  // stack writes land in memory
  always @(posedge mclk) begin
    if (bus_wr_reg === 1'b1) mem[bus_addr_reg] <= bus_wdata_reg;
  end

  cpu_reset_interrupt_sequencer i_dut (.mclk(mclk), .rst(rst), .last_cycle(last_cycle), .op_first(op_first),
    .next_opcode(next_opcode), .pc_in(pc_in), .x_in(x_in), .a_in(a_in), .ccr_in(ccr_in), .h_load(h_load),
    .h_in(h_in), .irq_pending(irq_pending), .irq_local_en(irq_local_en), .vec_code(vec_code),
    .internal_reset_src(internal_reset_src), .reset_pin_in(reset_pin_in), .monitor_strap(monitor_strap),
    .stop_enter(stop_enter), .wait_enter(wait_enter), .bus_rdata(bus_rdata), .bus_addr_reg(bus_addr_reg),
    .bus_wdata_reg(bus_wdata_reg), .bus_rd_reg(bus_rd_reg), .bus_wr_reg(bus_wr_reg),
    .opcode_holding_register(opcode_holding_register), .pc_reg(pc_reg), .pc_load_reg(pc_load_reg),
    .sp_reg(sp_reg), .h_reg(h_reg), .ccr_mask_reg(ccr_mask_reg), .a_restore_reg(a_restore_reg),
    .x_restore_reg(x_restore_reg), .ccr_restore_reg(ccr_restore_reg), .restore_valid_reg(restore_valid_reg),
    .seq_busy_reg(seq_busy_reg), .irq_ack_reg(irq_ack_reg), .monitor_mode_reg(monitor_mode_reg),
    .stop_latch_reg(stop_latch_reg), .wait_latch_reg(wait_latch_reg), .reset_pin_oe(reset_pin_oe),
    .internal_reset_flag(internal_reset_flag));

  sim_unit_model i_sim (.mclk(mclk), .rst(rst), .req_in(req), .code_in(req_code), .irq_ack(irq_ack_reg),
    .irq_pending(irq_pending), .vec_code(vec_code));

  ////////////////////////////////////////////////////////////////////////
  // expected vector contents for a code and mode
  function automatic logic [15:0] vec_pc(input logic [6:0] code, input logic mon);
    logic [15:0] v;
    v = VEC_USER_HI - {8'h00, code, 1'b0};
    if (mon) v[VEC_MONITOR_BIT] = 1'b0;
    return {mem[v], mem[v + 16'h0001]};
  endfunction : vec_pc

  // one final-cycle request from the core
  task automatic instr(input logic [7:0] op, input logic [15:0] pc);
    @(posedge mclk);
    last_cycle <= 1'b1;
    next_opcode <= op;
    pc_in <= pc;
    @(posedge mclk);
    last_cycle <= 1'b0;
  endtask : instr

  // bounded wait for the program counter load pulse
  task automatic wait_load(input string nm);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (pc_load_reg !== 1'b1 && n < 200);
    `CHK(nm, 1'b1, pc_load_reg)
  endtask : wait_load

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
    {last_cycle, op_first, h_load, req, internal_reset_src, monitor_strap, stop_enter, wait_enter} = 8'h00;
    {irq_local_en, ext_rst_n, rst} = 3'b111;
    next_opcode = 8'h01; pc_in = 16'h0000; h_in = 8'h00; req_code = 7'h00;
    x_in = 8'h3C; a_in = 8'h08; ccr_in = 8'h68;
    mops = '{clear_mask_op, acc_to_ccr_op, clear_mask_op};
    mexp = '{1'b0, 1'b1, 1'b0};
    bad_count = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wait_load("reset load");
    `CHK("sp", SP_RESET, sp_reg)
    `CHK("h", H_RESET, h_reg)
    `CHK("mask", 1'b1, ccr_mask_reg)
    `CHK("pc", vec_pc(VEC_CODE_RESET, 1'b0), pc_reg)
    `CHK("mode", 1'b0, monitor_mode_reg)
    `CHK("flag", 1'b0, internal_reset_flag)
    $display("test reset done");
    @(posedge mclk) h_load <= 1'b1; h_in <= 8'h5C;
    @(posedge mclk) h_load <= 1'b0;
    instr(software_trap_opcode, 16'h1235);
    wait_load("trap load");
    `CHK("sp", 16'h00FA, sp_reg)
    `CHK("pcl", 8'h35, mem[16'h00FF])
    `CHK("pch", 8'h12, mem[16'h00FE])
    `CHK("x", 8'h3C, mem[16'h00FD])
    `CHK("a", 8'h08, mem[16'h00FC])
    `CHK("ccr", 8'h68, mem[16'h00FB])
    `CHK("pc", vec_pc(VEC_CODE_TRAP, 1'b0), pc_reg)
    `CHK("h", 8'h5C, h_reg)
    `CHK("ack", 1'b0, irq_ack_reg)
    instr(return_from_exception_op, 16'h4000);
    wait_load("return load");
    `CHK("pc", 16'h1235, pc_reg)
    `CHK("sp", 16'h00FF, sp_reg)
    `CHK("x", 8'h3C, x_restore_reg)
    `CHK("a", 8'h08, a_restore_reg)
    `CHK("ccr", 8'h68, ccr_restore_reg)
    `CHK("valid", 1'b1, restore_valid_reg)
    `CHK("mask", 1'b1, ccr_mask_reg)
    $display("test trap done");
    for (int k = 0; k < 3; k++) begin
      instr(mops[k], 16'h1300);
      @(posedge mclk) op_first <= 1'b1;
      @(posedge mclk) op_first <= 1'b0;
      #1;
      `CHK("mask op", mexp[k], ccr_mask_reg)
    end
    $display("test mask done");
    @(posedge mclk) ccr_in <= 8'h60;
    irq_local_en <= 1'b0;
    @(posedge mclk) req <= 1'b1; req_code <= 7'h02;
    @(posedge mclk) req_code <= 7'h03;
    @(posedge mclk) req <= 1'b0;
    instr(8'h01, 16'h1400);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("blocked", 1'b0, seq_busy_reg)
    @(posedge mclk) irq_local_en <= 1'b1;
    repeat (2) @(posedge mclk);
    instr(8'h01, 16'h2000);
    wait_load("irq load");
    `CHK("pcl", 8'hFF, mem[16'h00FF])
    `CHK("pch", 8'h1F, mem[16'h00FE])
    `CHK("ccr", 8'h60, mem[16'h00FB])
    `CHK("pc", vec_pc(7'h02, 1'b0), pc_reg)
    `CHK("opcode", software_trap_opcode, opcode_holding_register)
    `CHK("ack", 1'b1, irq_ack_reg)
    `CHK("mask", 1'b1, ccr_mask_reg)
    mem[16'h00FB] = 8'h68;
    instr(return_from_exception_op, 16'h4000);
    wait_load("return load");
    `CHK("pc", 16'h1FFF, pc_reg)
    `CHK("mask", 1'b1, ccr_mask_reg)
    $display("test irq done");
    @(posedge mclk) stop_enter <= 1'b1; wait_enter <= 1'b1; monitor_strap <= 1'b1;
    @(posedge mclk) stop_enter <= 1'b0; wait_enter <= 1'b0; internal_reset_src <= 1'b1;
    @(posedge mclk) internal_reset_src <= 1'b0;
    #1;
    n = (reset_pin_oe === 1'b1) ? 1 : 0;
    `CHK("latches set", 2'b11, {stop_latch_reg, wait_latch_reg})
    for (int k = 0; k < 200 && pc_load_reg !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
      if (reset_pin_oe === 1'b1) n++;
    end
    `CHK("pin low cycles", 16, n)
    `CHK("flag", 1'b1, internal_reset_flag)
    `CHK("mode", 1'b1, monitor_mode_reg)
    `CHK("pc", vec_pc(VEC_CODE_RESET, 1'b1), pc_reg)
    `CHK("latches", 2'b00, {stop_latch_reg, wait_latch_reg})
    `CHK("sp", SP_RESET, sp_reg)
    $display("test internal reset done");
    end_of_test();
  end
endmodule : tb_cpu_reset_interrupt_sequencer
